// >>> rtl/mesr_pkg.sv
package mesr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TIME_CTRL   = 8'h19;
    localparam logic [7:0] ADDR_ALL_SUMMARY = 8'h1A;
    localparam logic [7:0] ADDR_WAKE_SRC    = 8'h1B;
    localparam logic [7:0] ADDR_KNOCK_SRC   = 8'h1C;
    localparam logic [7:0] ADDR_TIME_B0     = 8'h40;
    localparam logic [7:0] ADDR_TIME_B1     = 8'h41;
    localparam logic [7:0] ADDR_TIME_B2     = 8'h42;
    localparam logic [7:0] ADDR_TIME_B3     = 8'h43;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Control register
    localparam int CTRL_TIME_EN_BIT   = 5;
    // Summary register
    localparam int SUM_WRAP_BIT       = 7;
    localparam int SUM_ACT_CHG_BIT    = 5;
    localparam int SUM_ORIENT_BIT     = 4;
    localparam int SUM_DOUBLE_BIT     = 3;
    localparam int SUM_SINGLE_BIT     = 2;
    localparam int SUM_WAKE_BIT       = 1;
    localparam int SUM_FALL_BIT       = 0;
    // Wake source register
    localparam int WAKE_ACT_CHG_BIT   = 6;
    localparam int WAKE_FALL_BIT      = 5;
    localparam int WAKE_REST_BIT      = 4;
    localparam int WAKE_WAKE_BIT      = 3;
    localparam int WAKE_X_BIT         = 2;
    localparam int WAKE_Y_BIT         = 1;
    localparam int WAKE_Z_BIT         = 0;
    // Knock source register
    localparam int KNOCK_ANY_BIT      = 6;
    localparam int KNOCK_SINGLE_BIT   = 5;
    localparam int KNOCK_DOUBLE_BIT   = 4;
    localparam int KNOCK_SIGN_BIT     = 3;
    localparam int KNOCK_X_BIT        = 2;
    localparam int KNOCK_Y_BIT        = 1;
    localparam int KNOCK_Z_BIT        = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_TIME_CTRL = 8'h00;
    localparam logic [7:0] RST_SOURCE    = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 5;
    localparam int TICK_PERIOD_NS = 25000;
    localparam int WRAP_WARN_NS   = 6400000;
    localparam int TIME_CNT_W     = 32;
    // One counter step per tick period, at least one clock cycle
    localparam int TICK_CYCLES    = (TICK_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    TICK_PERIOD_NS / CLK_PERIOD_NS;
    // Warning window in counter steps, rounded down, at least one
    localparam int WARN_TICKS     = (WRAP_WARN_NS / TICK_PERIOD_NS < 1) ? 1 :
                                    WRAP_WARN_NS / TICK_PERIOD_NS;

endpackage : mesr_pkg

// >>> rtl/mesr_event_latch.sv
`timescale 1ns/100ps

module mesr_event_latch #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] sets,
    input  wire logic         clear,
    output logic      [W-1:0] flag_q
);

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    // Set beats clear so an event arriving during the clearing read survives
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_q[i] <= 1'b0;
                end else if (sets[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (clear) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : mesr_event_latch

// >>> rtl/mesr_time_counter.sv
`timescale 1ns/100ps

module mesr_time_counter #(
    parameter int TICK_CYCLES = 5000,
    parameter int WARN_TICKS  = 256,
    parameter int CNT_W       = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             enable,
    output logic      [CNT_W-1:0] count_q,
    output logic                  near_wrap
);

    localparam int DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(TICK_CYCLES - 1);
    localparam logic [CNT_W-1:0] WARN_FROM = {CNT_W{1'b1}} - CNT_W'(WARN_TICKS) + 1'b1;

    logic [DIV_W-1:0] div_q;
    logic             tick;

    // ------------------------------------------------------------------
    // Tick divider
    // ------------------------------------------------------------------
    // Divider rests while disabled so a restart begins a full period
    assign tick = enable && (div_q == DIV_LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (!enable || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Value is held, not cleared, while disabled; wraps to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Level while the last WARN_TICKS steps before overflow are running
    assign near_wrap = (count_q >= WARN_FROM);

endmodule : mesr_time_counter

// >>> rtl/mesr_top.sv
`timescale 1ns/100ps

// Operation
// - Control register 19h holds time counter enable, reset 0, 1 counts.
// - Running time counter readable as four bytes at 40h to 43h.
// - Wrap warning flag set while counter is within 6.4 ms of overflow.
// - Read-only summary at 1Ah gathers wrap and event flags, reset 0.
// - Activity change flag set on activity status change, in summary and wake.
// - Orientation change flag set on position change, reset 0.
// - Read-only wake source at 1Bh with change, fall, rest, wake, axes.
// - Fall flag in wake source reports free-fall event, reset 0.
// - Rest-state bit is 1 while sleep is detected, reset 0.
// - Wake flag set on wake-up event, reset 0.
// - Separate X, Y, Z wake flags per detecting axis, reset 0.
// - Read-only knock source at 1Ch, knock flag set on any knock.
// - Single-knock flag set on single knock, in knock and summary.
// - Double-knock flag set on double knock, reset 0.
// - Knock sign reports acceleration sign, 0 positive, 1 negative.
// - Separate X, Y, Z knock flags per detecting axis, reset 0.

module mesr_top #(
    parameter int TICK_CYCLES = mesr_pkg::TICK_CYCLES,
    parameter int WARN_TICKS  = mesr_pkg::WARN_TICKS,
    parameter int CNT_W       = mesr_pkg::TIME_CNT_W
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port from the serial interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rd_data_q,
    output logic            reg_rd_valid_q,
    // Event pulses from the detection engines
    input  wire logic       fall_evt,
    input  wire logic       wake_evt,
    input  wire logic [2:0] wake_axis,
    input  wire logic       activity_change_evt,
    input  wire logic       rest_state,
    input  wire logic       orientation_evt,
    input  wire logic       single_knock_evt,
    input  wire logic       double_knock_evt,
    input  wire logic       knock_sign,
    input  wire logic [2:0] knock_axis,
    // Counter state toward other logic
    output logic            time_count_en,
    output logic [CNT_W-1:0] time_count
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int NWAKE  = 6;
    localparam int NKNOCK = 6;

    logic             time_en_q;
    logic             time_count_wrap_flag;
    logic [CNT_W-1:0] count_val;
    logic [23:0]      time_hi_q;
    logic [7:0]       rd_mux;
    logic [7:0]       all_event_summary;
    logic [7:0]       wake_event_source;
    logic [7:0]       knock_event_source;

    logic             rd_summary;
    logic             rd_wake;
    logic             rd_knock;

    logic [NWAKE-1:0]  wake_set;
    logic [NWAKE-1:0]  wake_q;
    logic [NKNOCK-1:0] knock_set;
    logic [NKNOCK-1:0] knock_q;
    logic              orient_q;
    logic              knock_sign_q;
    logic              any_knock;

    logic activity_change_flag;
    logic fall_flag;
    logic wake_flag;
    logic x_wake_flag;
    logic y_wake_flag;
    logic z_wake_flag;
    logic knock_flag;
    logic single_knock_flag;
    logic double_knock_flag;
    logic x_knock_flag;
    logic y_knock_flag;
    logic z_knock_flag;
    logic orientation_change_flag;

    // ------------------------------------------------------------------
    // Read strobes that clear source flags
    // ------------------------------------------------------------------
    // Summary read clears every event it shows; source reads clear their own
    assign rd_summary = reg_rd_en && (reg_addr == mesr_pkg::ADDR_ALL_SUMMARY);
    assign rd_wake    = reg_rd_en && (reg_addr == mesr_pkg::ADDR_WAKE_SRC);
    assign rd_knock   = reg_rd_en && (reg_addr == mesr_pkg::ADDR_KNOCK_SRC);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // enable bit store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_en_q <= mesr_pkg::RST_TIME_CTRL[mesr_pkg::CTRL_TIME_EN_BIT];
        end else if (reg_wr_en && (reg_addr == mesr_pkg::ADDR_TIME_CTRL)) begin
            time_en_q <= reg_wr_data[mesr_pkg::CTRL_TIME_EN_BIT];
        end
    end

    assign time_count_en = time_en_q;

    // ------------------------------------------------------------------
    // Time counter
    // ------------------------------------------------------------------
    // counter gated by enable
    mesr_time_counter #(
        .TICK_CYCLES (TICK_CYCLES),
        .WARN_TICKS  (WARN_TICKS),
        .CNT_W       (CNT_W)
    ) u_time_counter (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (time_en_q),
        .count_q   (count_val),
        .near_wrap (time_count_wrap_flag)
    );

    assign time_count = count_val;

    // upper bytes snapshot
    // Reading the low byte freezes the upper three, so a multi-byte read
    // cannot tear across a carry; a limitation is that they must follow it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_hi_q <= 24'h000000;
        end else if (reg_rd_en && (reg_addr == mesr_pkg::ADDR_TIME_B0)) begin
            time_hi_q <= count_val[31:8];
        end
    end

    // ------------------------------------------------------------------
    // Wake source flags
    // ------------------------------------------------------------------
    // activity change latch
    assign wake_set = {activity_change_evt,
                       fall_evt,
                       wake_evt,
                       wake_evt & wake_axis[2],
                       wake_evt & wake_axis[1],
                       wake_evt & wake_axis[0]};

    mesr_event_latch #(
        .W (NWAKE)
    ) u_wake_latch (
        .clk    (clk),
        .rst_n  (rst_n),
        .sets   (wake_set),
        .clear  (rd_wake | rd_summary),
        .flag_q (wake_q)
    );

    assign activity_change_flag = wake_q[5];
    assign fall_flag            = wake_q[4];
    assign wake_flag            = wake_q[3];
    assign x_wake_flag          = wake_q[2];
    assign y_wake_flag          = wake_q[1];
    assign z_wake_flag          = wake_q[0];

    // ------------------------------------------------------------------
    // Knock source flags
    // ------------------------------------------------------------------
    // any knock sets
    assign any_knock = single_knock_evt | double_knock_evt;
    assign knock_set = {any_knock,
                        single_knock_evt,
                        double_knock_evt,
                        any_knock & knock_axis[2],
                        any_knock & knock_axis[1],
                        any_knock & knock_axis[0]};

    mesr_event_latch #(
        .W (NKNOCK)
    ) u_knock_latch (
        .clk    (clk),
        .rst_n  (rst_n),
        .sets   (knock_set),
        .clear  (rd_knock | rd_summary),
        .flag_q (knock_q)
    );

    assign knock_flag        = knock_q[5];
    assign single_knock_flag = knock_q[4];
    assign double_knock_flag = knock_q[3];
    assign x_knock_flag      = knock_q[2];
    assign y_knock_flag      = knock_q[1];
    assign z_knock_flag      = knock_q[0];

    // sign captured per knock
    // Sign is a value, not a sticky flag: the latest knock overwrites it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            knock_sign_q <= 1'b0;
        end else if (any_knock) begin
            knock_sign_q <= knock_sign;
        end else if (rd_knock | rd_summary) begin
            knock_sign_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Orientation change flag
    // ------------------------------------------------------------------
    // orientation change latch
    // Only the summary read clears it here; new change wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            orient_q <= 1'b0;
        end else if (orientation_evt) begin
            orient_q <= 1'b1;
        end else if (rd_summary) begin
            orient_q <= 1'b0;
        end
    end

    assign orientation_change_flag = orient_q;

    // ------------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------------
    // summary gathers flags
    always_comb begin
        all_event_summary = mesr_pkg::RST_SOURCE;
        all_event_summary[mesr_pkg::SUM_WRAP_BIT]    = time_count_wrap_flag;
        all_event_summary[mesr_pkg::SUM_ACT_CHG_BIT] = activity_change_flag;
        all_event_summary[mesr_pkg::SUM_ORIENT_BIT]  = orientation_change_flag;
        all_event_summary[mesr_pkg::SUM_DOUBLE_BIT]  = double_knock_flag;
        all_event_summary[mesr_pkg::SUM_SINGLE_BIT]  = single_knock_flag;
        all_event_summary[mesr_pkg::SUM_WAKE_BIT]    = wake_flag;
        all_event_summary[mesr_pkg::SUM_FALL_BIT]    = fall_flag;
    end

    always_comb begin
        wake_event_source = mesr_pkg::RST_SOURCE;
        wake_event_source[mesr_pkg::WAKE_ACT_CHG_BIT] = activity_change_flag;
        wake_event_source[mesr_pkg::WAKE_FALL_BIT]    = fall_flag;
        wake_event_source[mesr_pkg::WAKE_REST_BIT]    = rest_state;
        wake_event_source[mesr_pkg::WAKE_WAKE_BIT]    = wake_flag;
        wake_event_source[mesr_pkg::WAKE_X_BIT]       = x_wake_flag;
        wake_event_source[mesr_pkg::WAKE_Y_BIT]       = y_wake_flag;
        wake_event_source[mesr_pkg::WAKE_Z_BIT]       = z_wake_flag;
    end

    always_comb begin
        knock_event_source = mesr_pkg::RST_SOURCE;
        knock_event_source[mesr_pkg::KNOCK_ANY_BIT]    = knock_flag;
        knock_event_source[mesr_pkg::KNOCK_SINGLE_BIT] = single_knock_flag;
        knock_event_source[mesr_pkg::KNOCK_DOUBLE_BIT] = double_knock_flag;
        knock_event_source[mesr_pkg::KNOCK_SIGN_BIT]   = knock_sign_q;
        knock_event_source[mesr_pkg::KNOCK_X_BIT]      = x_knock_flag;
        knock_event_source[mesr_pkg::KNOCK_Y_BIT]      = y_knock_flag;
        knock_event_source[mesr_pkg::KNOCK_Z_BIT]      = z_knock_flag;
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // byte select of counter
    // Bytes above the low one come from the snapshot taken with it
    always_comb begin
        rd_mux = mesr_pkg::RD_UNMAPPED;
        unique case (reg_addr)
            mesr_pkg::ADDR_TIME_CTRL: begin
                rd_mux[mesr_pkg::CTRL_TIME_EN_BIT] = time_en_q;
            end
            mesr_pkg::ADDR_ALL_SUMMARY: rd_mux = all_event_summary;
            mesr_pkg::ADDR_WAKE_SRC:    rd_mux = wake_event_source;
            mesr_pkg::ADDR_KNOCK_SRC:   rd_mux = knock_event_source;
            mesr_pkg::ADDR_TIME_B0:     rd_mux = count_val[7:0];
            mesr_pkg::ADDR_TIME_B1:     rd_mux = time_hi_q[7:0];
            mesr_pkg::ADDR_TIME_B2:     rd_mux = time_hi_q[15:8];
            mesr_pkg::ADDR_TIME_B3:     rd_mux = time_hi_q[23:16];
            default:                    rd_mux = mesr_pkg::RD_UNMAPPED;
        endcase
    end

    // Read data registered one cycle after the strobe; held until next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data_q <= mesr_pkg::RD_UNMAPPED;
        end else if (reg_rd_en) begin
            reg_rd_data_q <= rd_mux;
        end
    end

    // Valid pulse marks the cycle the new read data appears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_valid_q <= 1'b0;
        end else begin
            reg_rd_valid_q <= reg_rd_en;
        end
    end

endmodule : mesr_top

// >>> testbench/mesr_chk.sv
`timescale 1ns/100ps

module mesr_chk #(
    parameter int CNT_W      = 32,
    parameter int WARN_TICKS = 256
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic [7:0]       reg_addr,
    input wire logic             reg_wr_en,
    input wire logic [7:0]       reg_wr_data,
    input wire logic             reg_rd_en,
    input wire logic [7:0]       reg_rd_data_q,
    input wire logic             reg_rd_valid_q,
    input wire logic             fall_evt,
    input wire logic             wake_evt,
    input wire logic [2:0]       wake_axis,
    input wire logic             rest_state,
    input wire logic             single_knock_evt,
    input wire logic             double_knock_evt,
    input wire logic             knock_sign,
    input wire logic             time_count_en,
    input wire logic [CNT_W-1:0] time_count
);
    // ----------------------------------------
    // Decoded strobes
    // ----------------------------------------
    localparam longint WRAP_AT = (longint'(1) << CNT_W) - WARN_TICKS;
    logic wr_ctrl, rd_sum, rd_wake, rd_knock, rd_map, en_bit;
    assign wr_ctrl  = reg_wr_en && reg_addr == mesr_pkg::ADDR_TIME_CTRL;
    assign rd_sum   = reg_rd_en && reg_addr == mesr_pkg::ADDR_ALL_SUMMARY;
    assign rd_wake  = reg_rd_en && reg_addr == mesr_pkg::ADDR_WAKE_SRC;
    assign rd_knock = reg_rd_en && reg_addr == mesr_pkg::ADDR_KNOCK_SRC;
    assign rd_map   = reg_addr inside {[8'h19:8'h1C], [8'h40:8'h43]};
    assign en_bit   = reg_wr_data[mesr_pkg::CTRL_TIME_EN_BIT];
    // One domain, so clock and reset are given once
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // read answer timing
    a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid_q)
        else $error("read strobe got no answer");
    a_ctrl_write: assert property (wr_ctrl |=> time_count_en == $past(en_bit))
        else $error("enable bit not taken from write");
    a_ctrl_hold: assert property (!wr_ctrl |=> $stable(time_count_en))
        else $error("enable bit moved without write");
    // counter steps by one only while enabled
    a_count_step: assert property ((time_count != $past(time_count)) |->
        $past(time_count_en) && time_count == CNT_W'($past(time_count) + 1))
        else $error("counter moved wrongly");
    a_wrap_flag: assert property (rd_sum |=>
        reg_rd_data_q[7] == ($past(time_count) >= WRAP_AT))
        else $error("wrap warning wrong");
    a_rest_level: assert property (rd_wake |=> reg_rd_data_q[4] == $past(rest_state))
        else $error("rest bit wrong");
    a_unmapped_zero: assert property (reg_rd_en && !rd_map |=> reg_rd_data_q == 8'h00)
        else $error("unmapped read not zero");
    a_wake_sets: assert property (wake_evt ##1 rd_wake |=> reg_rd_data_q[3] &&
        (reg_rd_data_q[2:0] & $past(wake_axis, 2)) == $past(wake_axis, 2))
        else $error("wake flags not set");
    a_fall_sets: assert property (fall_evt ##1 rd_wake |=> reg_rd_data_q[5])
        else $error("fall flag not set");
    a_knock_sign: assert property (
        (single_knock_evt || double_knock_evt) ##1 rd_knock |=>
        reg_rd_data_q[6] && reg_rd_data_q[3] == $past(knock_sign, 2))
        else $error("knock flag or sign wrong");
    // Main scenarios
    c_wake_read: cover property (wake_evt ##1 rd_wake);
    c_knock_read: cover property (single_knock_evt ##1 rd_knock);
    c_ctrl_write: cover property (wr_ctrl && en_bit);
endmodule : mesr_chk

bind mesr_top mesr_chk #(.CNT_W(CNT_W), .WARN_TICKS(WARN_TICKS)) u_chk (
    .clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data_q,
    .reg_rd_valid_q, .fall_evt, .wake_evt, .wake_axis, .rest_state, .single_knock_evt,
    .double_knock_evt, .knock_sign, .time_count_en, .time_count);

// >>> testbench/mesr_host.sv
`timescale 1ns/100ps

module mesr_host (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rd_data_q,
    input  wire logic       reg_rd_valid_q
);
    // Idle port values at time zero
    initial begin
        reg_addr    = 8'h00;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end

    // reserved control bits sent as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr    <= a;
        reg_wr_en   <= 1'b1;
        reg_wr_data <= (a == mesr_pkg::ADDR_TIME_CTRL) ? (d & 8'h20) : d;
        @(posedge clk);
        reg_wr_en   <= 1'b0;
        reg_addr    <= ~a;
        reg_wr_data <= ~d;
    endtask : wr

    // Answer taken once the strobe edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1;
        v = reg_rd_valid_q;
        d = reg_rd_data_q;
    endtask : rd
endmodule : mesr_host

// >>> testbench/tb.sv
`timescale 1ns/100ps

module tb;
    localparam int TICK = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr, reg_wr_data, reg_rd_data_q;
    logic        reg_wr_en, reg_rd_en, reg_rd_valid_q, time_count_en;
    logic [31:0] time_count;
    logic [5:0]  ev = '0;
    logic [2:0]  wake_axis = '0, knock_axis = '0;
    logic        rest_state = 1'b0, knock_sign = 1'b0;
    // Model flags
    logic        act = 1'b0, ori = 1'b0, fal = 1'b0, wak = 1'b0;
    logic        sgl = 1'b0, dbl = 1'b0, sgn = 1'b0;
    logic [2:0]  wax = '0, kax = '0;
    logic [15:0] lf = 16'h71E9; // Seed 29161
    logic [7:0]  adr [9] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h40, 8'h41, 8'h42, 8'h43, 8'h55};
    int          error_cnt = 0, checks_done = 0, cyc = 0, t0;

    mesr_top #(.TICK_CYCLES(TICK)) DUT (
        .clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data_q,
        .reg_rd_valid_q, .fall_evt(ev[0]), .wake_evt(ev[1]), .wake_axis,
        .activity_change_evt(ev[2]), .rest_state, .orientation_evt(ev[3]),
        .single_knock_evt(ev[4]), .double_knock_evt(ev[5]), .knock_sign, .knock_axis,
        .time_count_en, .time_count);
    mesr_host host (.clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data_q,
        .reg_rd_valid_q);

    always #2.5 clk = ~clk;
    // Cycle count; a hang ends the run as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            wrap_up();
        end
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction : nxt

    // Expected image; wrap bit is 0 as the count stays far from the top
    function automatic logic [7:0] img(input logic [7:0] a);
        case (a)
            8'h1A: return {2'b00, act, ori, dbl, sgl, wak, fal};
            8'h1B: return {1'b0, act, fal, rest_state, wak, wax};
            8'h1C: return {1'b0, sgl | dbl, sgl, dbl, sgn, kax};
            default: return 8'h00;
        endcase
    endfunction : img

    task automatic clr(input logic [7:0] a);
        if (a == 8'h1A || a == 8'h1B) {act, fal, wak, wax} = '0;
        if (a == 8'h1A) ori = 1'b0;
        if (a == 8'h1A || a == 8'h1C) {sgl, dbl, sgn, kax} = '0;
    endtask : clr

    task automatic apply(input logic [15:0] r);
        {dbl, sgl, ori, act, wak, fal} = {dbl, sgl, ori, act, wak, fal} | r[5:0];
        if (r[1]) wax |= r[8:6];
        if (r[4] | r[5]) begin
            kax |= r[11:9];
            sgn = r[12];
        end
    endtask : apply

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        logic       v;
        host.rd(a, g, v);
        chk($sformatf("reg %h", a), {1'b1, e}, {v, g});
    endtask : rdc

    // Random events with a read in the same or the next cycle
    task automatic step;
        logic [15:0] r;
        logic [7:0]  a, e, g;
        logic        v;
        r  = lf;
        lf = nxt(nxt(lf));
        a  = 8'h1A + lf[9:8];
        fork
            begin
                repeat (r[14]) @(posedge clk);
                host.rd(a, g, v);
            end
            begin
                @(posedge clk);
                ev         <= r[5:0];
                wake_axis  <= r[8:6];
                knock_axis <= r[11:9];
                knock_sign <= r[12];
                rest_state <= r[13];
                @(posedge clk);
                ev         <= '0;
            end
        join
        // A late read sees the event; a same-cycle event outlives the clear
        if (r[14]) apply(r);
        e = img(a);
        clr(a);
        if (!r[14]) apply(r);
        chk($sformatf("reg %h", a), {1'b1, e}, {v, g});
    endtask : step

    task automatic wrap_up;
        $display("checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (adr[i]) rdc(adr[i], 8'h00);
        host.wr(8'h1B, 8'hFF);
        host.wr(8'h1A, 8'hFF);
        rdc(8'h1B, 8'h00);
        rdc(8'h1A, 8'h00);
        host.wr(8'h19, 8'h20);
        #1 t0 = cyc;
        rdc(8'h19, 8'h20);
        repeat (37) @(posedge clk);
        host.wr(8'h19, 8'h00);
        #1 t0 = (cyc - t0) / TICK;
        rdc(8'h19, 8'h00);
        repeat (5) @(posedge clk);
        for (int i = 0; i < 4; i++) rdc(8'(8'h40 + i), 8'(t0 >> (8 * i)));
        chk("time_count", t0, time_count);
        repeat (80) step();
        wrap_up();
    end
endmodule : tb
